//--- adc_window_detector_tb.sv
/* adc_window_detector_tb: register and window tests of awd_window.
   Assumes the core model drives the bus and the bench plays the converter. */
`timescale 1ns/100ps
`default_nettype none
module adc_window_detector_tb;
   import awd_pkg::*;
   logic        i_clk, i_rst, i_start, i_diff, i_lj, wr, busy, flag;
   logic [9:0]  i_sample;
   logic [4:0]  i_sar_div;
   logic [7:0]  addr, wdata, rdata, d;
   logic [15:0] res;
   int          n_errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   always #5 i_clk = ~i_clk;
   awd_core_model u_core (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr));
   awd_window #(.CONV_CLKS(AWD_CONV_SAR_CLKS)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .o_rdata(rdata), .i_start(i_start),
      .i_sample(i_sample), .i_diff_mode(i_diff), .i_left_justify_select(i_lj),
      .i_sar_div(i_sar_div), .o_busy(busy), .o_window_match_flag(flag),
      .o_result_word(res));
   // ==========================================================
   // checking and closing
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // hang guard, well above the roughly 450 cycles the tests need
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ==========================================================
   // one conversion; keep skips the flag clear to probe stickiness
   task automatic conv(input logic [9:0] s, input logic hit, input int dv, input logic keep);
      int n;
      if (!keep) u_core.wr(AWD_ADDR_CONTROL, 8'h00);
      @(posedge i_clk);
      i_start   <= 1'b1;
      i_sample  <= s;
      i_sar_div <= dv[4:0];
      @(posedge i_clk);
      i_start <= 1'b0;
      n = 0;
      #1;
      while (busy === 1'b1 && n < 400) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk(16'(n), 16'(AWD_CONV_SAR_CLKS * (dv + 1)));
      chk(res, i_lj ? {s, 6'h00} : i_diff ? {{6{s[9]}}, s} : {6'h00, s});
      @(posedge i_clk);
      #1 chk({15'h0000, flag}, {15'h0000, hit});
      u_core.rd(AWD_ADDR_CONTROL, d);
      chk({8'h00, d}, {12'h000, hit, 3'h0});
   endtask : conv
   // ==========================================================
   // main sequence
   initial begin
      i_clk = 1'b0;
      i_rst = 1'b1;
      i_start = 1'b0;
      i_sample = 10'h000;
      i_diff = 1'b0;
      i_lj = 1'b0;
      i_sar_div = 5'h00;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      u_core.rd(AWD_ADDR_UPPER_LO, d);
      chk({8'h00, d}, 16'h0000);
      chk({14'h0000, busy, flag}, 16'h0000);
      u_core.wr(AWD_ADDR_UPPER_LO, 8'hA5);
      u_core.rd(AWD_ADDR_UPPER_LO, d);
      chk({8'h00, d}, 16'h00A5);
      u_core.rd(8'h00, d);
      chk({8'h00, d}, 16'h0000);
      $display("register test done");
      u_core.set_limits(16'h0040, 16'h0080);
      conv(10'h040, 0, 0, 0); conv(10'h041, 1, 0, 0);
      conv(10'h07F, 1, 0, 0); conv(10'h080, 0, 0, 0);
      $display("unsigned inside test done");
      u_core.set_limits(16'h0080, 16'h0040);
      conv(10'h03F, 1, 0, 0); conv(10'h040, 0, 0, 0); conv(10'h080, 0, 0, 0);
      conv(10'h081, 1, 0, 0); conv(10'h3FF, 1, 0, 0);
      conv(10'h060, 1, 0, 1); conv(10'h000, 1, 1, 0);
      $display("unsigned outside test done");
      @(posedge i_clk) i_diff <= 1'b1;
      u_core.set_limits(16'hFFFF, 16'h0040);
      conv(10'h000, 1, 0, 0); conv(10'h3FF, 0, 0, 0); conv(10'h03F, 1, 0, 0);
      conv(10'h040, 0, 0, 0); conv(10'h200, 0, 0, 0);
      u_core.set_limits(16'h0040, 16'hFFFF);
      conv(10'h3FE, 1, 0, 0); conv(10'h3FF, 0, 0, 0);
      conv(10'h041, 1, 0, 0); conv(10'h000, 0, 0, 0);
      $display("signed test done");
      @(posedge i_clk) i_diff <= 1'b0;
      i_lj <= 1'b1;
      u_core.set_limits(16'h1000, 16'h2000);
      conv(10'h041, 1, 0, 0); conv(10'h040, 0, 0, 0);
      conv(10'h3FF, 0, 0, 0);
      $display("left justified test done");
      end_of_test();
   end
endmodule : adc_window_detector_tb
`default_nettype wire

//--- awd_cmp_if.sv
/*
 * awd_cmp_if: carries one word and both limits to the comparator.
 * Assumes all words share one justification and signedness.
 */
`timescale 1ns/100ps
`default_nettype none
interface awd_cmp_if;
   logic [15:0] word;
   logic [15:0] lower;
   logic [15:0] upper;
   logic        signed_mode;
   logic        hit;
   modport src (output word, output lower, output upper, output signed_mode, input hit);
   modport cmp (input word, input lower, input upper, input signed_mode, output hit);
endinterface : awd_cmp_if
`default_nettype wire

//--- awd_compare.sv
/*
 * awd_compare: combinational window test of one result word.
 * Assumes the caller registers the hit.
 */
`timescale 1ns/100ps
`default_nettype none
module awd_compare (
   awd_cmp_if.cmp cmp
);
   logic gt_low;
   logic lt_up;
   logic inside_cfg;
   // ==========================================================
   // signed view flips the sign bit so one unsigned compare serves
   logic [15:0] w;
   logic [15:0] lo;
   logic [15:0] up;
   always_comb begin
      w  = cmp.word  ^ {cmp.signed_mode, 15'h0000};
      lo = cmp.lower ^ {cmp.signed_mode, 15'h0000};
      up = cmp.upper ^ {cmp.signed_mode, 15'h0000};
      inside_cfg = (lo < up);
      gt_low = (w > lo);
      lt_up  = (w < up);
      if (inside_cfg) begin
         cmp.hit = gt_low && lt_up;
      end else begin
         // swapped bounds: below upper or above lower
         cmp.hit = (w < up) || (w > lo);
      end
   end
endmodule : awd_compare
`default_nettype wire

//--- awd_core_model.sv
/* awd_core_model: the processor core on the byte register bus.
   Assumes one-cycle write strobes and read data one cycle after the address. */
`timescale 1ns/100ps
`default_nettype none
module awd_core_model
   import awd_pkg::*;
(
   // register bus
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output var  logic [7:0] o_addr,
   output var  logic [7:0] o_wdata,
   output var  logic       o_wr
);
   initial begin
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_wdata <= ~d; // stale data must not look valid
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      @(posedge i_clk);
      #1 d = i_rdata;
   endtask : rd
   // limits written in the same format as the result word
   task automatic set_limits(input logic [15:0] lo, input logic [15:0] up);
      wr(AWD_ADDR_LOWER_LO, lo[7:0]);
      wr(AWD_ADDR_LOWER_HI, lo[15:8]);
      wr(AWD_ADDR_UPPER_LO, up[7:0]);
      wr(AWD_ADDR_UPPER_HI, up[15:8]);
   endtask : set_limits
endmodule : awd_core_model
`default_nettype wire

//--- awd_pkg.sv
/*
 * awd_pkg: constants for the converter window detector.
 * Assumes an 8-bit special function register bus with a byte address.
 */
package awd_pkg;
   // ==========================================================
   // register addresses
   localparam logic [7:0] AWD_ADDR_UPPER_LO  = 8'hC5;
   localparam logic [7:0] AWD_ADDR_UPPER_HI  = 8'hC6;
   localparam logic [7:0] AWD_ADDR_LOWER_LO  = 8'hC3;
   localparam logic [7:0] AWD_ADDR_LOWER_HI  = 8'hC4;
   localparam logic [7:0] AWD_ADDR_CONTROL   = 8'hE8;
   // ==========================================================
   // reset values, field positions and conversion constants
   localparam logic [7:0] AWD_RST_BYTE       = 8'h00;
   localparam int         AWD_CTL_FLAG_BIT   = 3;
   localparam int         AWD_RES_BITS       = 10;
   localparam int         AWD_CONV_SAR_CLKS  = 10;
   localparam logic [4:0] AWD_SAR_DIV_RST    = 5'h1F;
endpackage : awd_pkg

//--- awd_window.sv
/*
 * awd_window: limit registers, conversion timing and window flag.
 * Assumes the core gives one-cycle write strobes and reads by address alone on the register bus
 * and that a result word arrives with a start pulse from the converter.
 */
// How it works
// - upper limit low byte at C5, reset zero
// - inside window: strictly between limits flags
// - outside window: strictly beyond limits flags
// - single-ended compares as unsigned values
// - differential compares as two's-complement values
// - signed example minus one to 64 works
// - conversion takes ten SAR clocks minimum
// - limit order alone picks inside or outside
`timescale 1ns/100ps
`default_nettype none
module awd_window
   import awd_pkg::*;
#(
   parameter int CONV_CLKS = AWD_CONV_SAR_CLKS
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // register bus
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   output logic      [7:0] o_rdata,
   // converter side
   input  wire logic       i_start,
   input  wire logic [9:0] i_sample,
   input  wire logic       i_diff_mode,
   input  wire logic       i_left_justify_select,
   input  wire logic [4:0] i_sar_div,
   // status
   output logic            o_busy,
   output logic            o_window_match_flag,
   output logic [15:0]     o_result_word
);
   // sar_cnt is five bits wide, so it can count no further than this
   localparam int CONV_CLKS_MAX = 32;
   if (CONV_CLKS < AWD_CONV_SAR_CLKS || CONV_CLKS > CONV_CLKS_MAX) begin : g_bad_conv
      $error("conversion count out of range");
   end
   // ==========================================================
   // state
   typedef enum logic [1:0] {
      AWD_IDLE = 2'b01,
      AWD_CONV = 2'b10
   } awd_st_type;
   typedef struct packed {
      awd_st_type  st;
      logic [7:0]  up_lo;
      logic [7:0]  up_hi;
      logic [7:0]  lo_lo;
      logic [7:0]  lo_hi;
      logic [4:0]  pre;
      logic [4:0]  sar_cnt;
      logic [9:0]  samp;
      logic [15:0] result;
      logic        done;
      logic        flag;
      logic [7:0]  rdata;
      logic        busy;
      logic [15:0] busy_len;
   } awd_state_type;
   awd_state_type s_r;
   awd_state_type s_nxt;
   awd_cmp_if ci ();
   logic [15:0] fmt;
   // ==========================================================
   // comparator hookup, compares the word just stored
   always_comb begin
      ci.word        = s_r.result;
      ci.lower       = {s_r.lo_hi, s_r.lo_lo};
      ci.upper       = {s_r.up_hi, s_r.up_lo};
      ci.signed_mode = i_diff_mode;
   end
   awd_compare u_cmp (
      .cmp (ci)
   );
   always_comb begin
      if (i_left_justify_select) begin
         fmt = {s_r.samp, 6'h00};
      end else begin
         fmt = {{6{s_r.samp[9] & i_diff_mode}}, s_r.samp};
      end
   end
   // ==========================================================
   // next state
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      // length of the running conversion, kept for the timing check only
      s_nxt.busy_len = s_r.busy ? (s_r.busy_len + 16'h0001) : 16'h0000;
      case (s_r.st)
         AWD_IDLE: begin
            if (i_start) begin
               s_nxt.st      = AWD_CONV;
               s_nxt.samp    = i_sample;
               s_nxt.pre     = 5'h00;
               s_nxt.sar_cnt = 5'h00;
            end
         end
         AWD_CONV: begin
            if (s_r.pre == i_sar_div) begin
               s_nxt.pre = 5'h00;
               if (s_r.sar_cnt == 5'(CONV_CLKS - 1)) begin
                  s_nxt.st     = AWD_IDLE;
                  s_nxt.result = fmt;
                  s_nxt.done   = 1'b1;
               end else begin
                  s_nxt.sar_cnt = s_r.sar_cnt + 5'h01;
               end
            end else begin
               s_nxt.pre = s_r.pre + 5'h01;
            end
         end
         default: s_nxt.st = AWD_IDLE;
      endcase
      if (i_wr) begin
         case (i_addr)
            AWD_ADDR_UPPER_LO: s_nxt.up_lo = i_wdata;
            AWD_ADDR_UPPER_HI: s_nxt.up_hi = i_wdata;
            AWD_ADDR_LOWER_LO: s_nxt.lo_lo = i_wdata;
            AWD_ADDR_LOWER_HI: s_nxt.lo_hi = i_wdata;
            AWD_ADDR_CONTROL: begin
               if (!i_wdata[AWD_CTL_FLAG_BIT]) begin
                  s_nxt.flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // set beats a simultaneous clear
      if (s_r.done && ci.hit) begin
         s_nxt.flag = 1'b1;
      end
      case (i_addr)
         AWD_ADDR_UPPER_LO: s_nxt.rdata = s_nxt.up_lo;
         AWD_ADDR_UPPER_HI: s_nxt.rdata = s_nxt.up_hi;
         AWD_ADDR_LOWER_LO: s_nxt.rdata = s_nxt.lo_lo;
         AWD_ADDR_LOWER_HI: s_nxt.rdata = s_nxt.lo_hi;
         AWD_ADDR_CONTROL: begin
            s_nxt.rdata                   = AWD_RST_BYTE;
            s_nxt.rdata[AWD_CTL_FLAG_BIT] = s_nxt.flag;
         end
         default:           s_nxt.rdata = AWD_RST_BYTE;
      endcase
      // busy as its own flop so the output needs no decode
      s_nxt.busy = (s_nxt.st == AWD_CONV);
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r.st      <= AWD_IDLE;
         s_r.up_lo   <= AWD_RST_BYTE;
         s_r.up_hi   <= AWD_RST_BYTE;
         s_r.lo_lo   <= AWD_RST_BYTE;
         s_r.lo_hi   <= AWD_RST_BYTE;
         s_r.pre     <= 5'h00;
         s_r.sar_cnt <= 5'h00;
         s_r.samp    <= 10'h000;
         s_r.result  <= 16'h0000;
         s_r.done    <= 1'b0;
         s_r.flag    <= 1'b0;
         s_r.rdata   <= AWD_RST_BYTE;
         s_r.busy    <= 1'b0;
         s_r.busy_len <= 16'h0000;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_rdata             = s_r.rdata;
   assign o_busy              = s_r.busy;
   assign o_window_match_flag = s_r.flag;
   assign o_result_word       = s_r.result;
   // ==========================================================
   // checks
   sequence s_hit_seen;
      s_r.done && ci.hit;
   endsequence
   property p_flag_set;
      @(posedge i_clk) disable iff (i_rst) s_hit_seen |=> o_window_match_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on hit");
   property p_flag_sticky;
      @(posedge i_clk) disable iff (i_rst)
         (o_window_match_flag && !i_wr) |=> o_window_match_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
   property p_inside;
      @(posedge i_clk) disable iff (i_rst)
         (s_r.done && ci.lower == 16'h0040 && ci.upper == 16'h0080 && !i_diff_mode
          && ci.word == 16'h0041) |-> ci.hit;
   endproperty
   a_inside: assert property (p_inside) else $error("inside miss");
   property p_edge_excl;
      @(posedge i_clk) disable iff (i_rst)
         (ci.lower == 16'h0040 && ci.upper == 16'h0080 && !i_diff_mode
          && (ci.word == 16'h0040 || ci.word == 16'h0080)) |-> !ci.hit;
   endproperty
   a_edge_excl: assert property (p_edge_excl) else $error("bound not exclusive");
   property p_outside;
      @(posedge i_clk) disable iff (i_rst)
         (ci.lower == 16'h0080 && ci.upper == 16'h0040 && !i_diff_mode
          && (ci.word == 16'h003F || ci.word == 16'h0081)) |-> ci.hit;
   endproperty
   a_outside: assert property (p_outside) else $error("outside miss");
   property p_signed;
      @(posedge i_clk) disable iff (i_rst)
         (ci.lower == 16'hFFFF && ci.upper == 16'h0040 && i_diff_mode
          && ci.word == 16'h0000) |-> ci.hit;
   endproperty
   a_signed: assert property (p_signed) else $error("signed miss");
   property p_unsigned;
      @(posedge i_clk) disable iff (i_rst)
         (ci.lower == 16'h1000 && ci.upper == 16'h2000 && !i_diff_mode
          && ci.word == 16'hFFC0) |-> !ci.hit;
   endproperty
   a_unsigned: assert property (p_unsigned) else $error("unsigned wrong");
   property p_conv_len;
      @(posedge i_clk) disable iff (i_rst)
         s_r.done |-> (int'(s_r.busy_len) == CONV_CLKS * (int'(i_sar_div) + 1));
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion short");
   property p_upper_wr;
      @(posedge i_clk) disable iff (i_rst)
         (i_wr && i_addr == AWD_ADDR_UPPER_LO) |=> (s_r.up_lo == $past(i_wdata));
   endproperty
   a_upper_wr: assert property (p_upper_wr) else $error("upper low not stored");
endmodule : awd_window
`default_nettype wire
